// >>> hw/smu_consts.svh
// Constants, register map and bit fields for the signed/unsigned multiply unit.
`ifndef SMU_CONSTS_SVH
`define SMU_CONSTS_SVH

// ------------------------------------------------------------------
// Arithmetic constants
// ------------------------------------------------------------------
`define SMU_ROUND_BIAS   64'h0000_0000_8000_0000
`define SMU_LATENCY      2

// ------------------------------------------------------------------
// Register map (word indices), control and status fields
// ------------------------------------------------------------------
`define SMU_ADDR_CTRL    4'h0
`define SMU_ADDR_FIRST   4'h1
`define SMU_ADDR_SECOND  4'h2
`define SMU_ADDR_ADDEND  4'h3
`define SMU_ADDR_LOWER   4'h4
`define SMU_ADDR_UPPER   4'h5
`define SMU_ADDR_RESULT  4'h6
`define SMU_ADDR_STATUS  4'h7
`define SMU_ADDR_MASK    4'h8
`define SMU_ADDR_FLAGS   4'h9
`define SMU_ADDR_WORDS   4

`define SMU_CTRL_OP_LSB  0
`define SMU_CTRL_ROUND   4
`define SMU_CTRL_SWAP    5
`define SMU_CTRL_XTOP    6
`define SMU_CTRL_YTOP    7
`define SMU_ST_DONE      0
`define SMU_ST_OVF       1

`endif

// >>> hw/smu_pkg.sv
// Types shared by the multiply unit.
package smu_pkg;
    typedef enum logic [3:0] {
        SMU_OP_HW_MAC, SMU_OP_HW_MSUB, SMU_OP_HW_PROD,
        SMU_OP_DUAL_SUM, SMU_OP_DUAL_DIFF, SMU_OP_HALF_PROD,
        SMU_OP_WORD_HALF, SMU_OP_UWIDE, SMU_OP_UWIDE_MAC,
        SMU_OP_SWIDE, SMU_OP_SWIDE_MAC
    } smu_op_t;
    typedef enum logic [1:0] {SMU_IDLE, SMU_CALC, SMU_WRITE} smu_state_t;
endpackage

// >>> hw/smu_mul_unit.sv
// Multiply datapath with an Avalon-MM register slave and interrupt.
`timescale 1ns/1ps
`include "smu_consts.svh"

module smu_mul_unit
    import smu_pkg::*;
(
    input  wire logic        clk_sys,           // Core clock, 50 MHz.
    input  wire logic        reset,             // Async reset, high.
    input  wire logic [5:0]  avs_address,       // Byte address.
    input  wire logic        avs_read,          // Read strobe.
    input  wire logic        avs_write,         // Write strobe.
    input  wire logic [31:0] avs_writedata,     // Write data.
    input  wire logic [3:0]  avs_byteenable,    // Byte lanes.
    output logic      [31:0] avs_readdata,      // Read data.
    output logic             avs_waitrequest,   // Stall the master.
    output logic             irq                // Level interrupt.
);

    // --------------------------------------------------------------
    // Helper functions
    // --------------------------------------------------------------
    // Pick a halfword by selector, sign extended.
    // Sign extension lets callers multiply at word width.
    function automatic logic signed [31:0] half_sel(
        input logic [31:0] w,
        input logic        top
    );
        half_sel = top ? 32'(signed'(w[31:16]))
                       : 32'(signed'(w[15:0]));
    endfunction

    // Merge write data with byte enables.
    // Lanes whose enable is low keep their old byte.
    function automatic logic [31:0] be_merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0]  be
    );
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        be_merge = m;
    endfunction

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    // Words that software reads over the bus, and all but result_q writes.
    logic [7:0]  ctrl_q;
    logic [31:0] first_factor_q;
    logic [31:0] second_factor_q;
    logic [31:0] addend_value_q;
    logic [31:0] lower_result_word_q;
    logic [31:0] upper_result_word_q;
    logic [31:0] result_q;
    logic [1:0]  status_q;
    logic [1:0]  mask_q;
    logic        sticky_ovf_q;

    // Working copies taken at start; the datapath reads only these.
    logic [31:0] op_a_q;
    logic [31:0] op_b_q;
    logic [31:0] op_c_q;
    logic [63:0] acc_q;
    smu_op_t     op_q;
    logic        round_q;
    logic        swap_q;
    logic        xtop_q;
    logic        ytop_q;

    // Sequencer and bus slave state.
    smu_state_t  state_q;
    logic [31:0] avs_readdata_q;
    logic        wait_q;
    logic        irq_q;

    // --------------------------------------------------------------
    // Bus decode
    // --------------------------------------------------------------
    // The word index is the byte address divided by four.
    wire [3:0] word_idx   = avs_address[5:2];
    // A request is first seen while waitrequest is still high.
    wire       acc_req    = (avs_read | avs_write) & wait_q;
    // A write commits at the edge where waitrequest is low, the edge
    // at which the master sees it complete.
    wire       wr_acc     = avs_write & !wait_q;

    // One strobe per writable word; writes to the result word and to unmapped words fall through.
    wire       hit_ctrl   = wr_acc & (word_idx == `SMU_ADDR_CTRL);
    wire       hit_first  = wr_acc & (word_idx == `SMU_ADDR_FIRST);
    wire       hit_second = wr_acc & (word_idx == `SMU_ADDR_SECOND);
    wire       hit_addend = wr_acc & (word_idx == `SMU_ADDR_ADDEND);
    wire       hit_lower  = wr_acc & (word_idx == `SMU_ADDR_LOWER);
    wire       hit_upper  = wr_acc & (word_idx == `SMU_ADDR_UPPER);
    wire       hit_status = wr_acc & (word_idx == `SMU_ADDR_STATUS);
    wire       hit_mask   = wr_acc & (word_idx == `SMU_ADDR_MASK);
    wire       hit_flags  = wr_acc & (word_idx == `SMU_ADDR_FLAGS);

    // Writing byte 0 of the control word with bit 3 set starts work.
    // Bit 3 is also the top bit of the operation code, so the code
    // and options come from the value held before this write: write
    // the options first, then repeat them with bit 3 set.
    wire       start      = hit_ctrl & avs_byteenable[0]
                            & avs_writedata[3]
                            & (state_q == SMU_IDLE);

    // --------------------------------------------------------------
    // Datapath
    // --------------------------------------------------------------
    // Pair selection for the dual operations.
    // With swap set the halves of the second factor trade places.
    wire signed [31:0] a_lo = half_sel(op_a_q, 1'b0);
    wire signed [31:0] a_hi = half_sel(op_a_q, 1'b1);
    wire signed [31:0] b_lo = half_sel(op_b_q, swap_q);
    wire signed [31:0] b_hi = half_sel(op_b_q, !swap_q);
    wire signed [31:0] p_lo = a_lo * b_lo;
    wire signed [31:0] p_hi = a_hi * b_hi;
    wire signed [32:0] dual_sum  = 33'(p_lo) + 33'(p_hi);
    wire        [31:0] dual_diff = p_lo - p_hi;
    // Overflow when the 33-bit sum does not fit 32 bits.
    // Each 16x16 product fits 32 bits, so only the sum can overflow.
    wire dual_ovf = dual_sum[32] ^ dual_sum[31];

    // Halfword by halfword product.
    // Each factor picks its own half independently.
    wire signed [31:0] hx = half_sel(op_a_q, xtop_q);
    wire signed [31:0] hy = half_sel(op_b_q, ytop_q);
    wire signed [31:0] half_prod = hx * hy;

    // Word by halfword: upper 32 of the 48-bit product.
    // Bits 63:48 of the container only repeat the sign.
    wire signed [63:0] wh_prod = 64'(signed'(op_a_q)) * 64'(hy);
    wire        [31:0] wh_top  = wh_prod[47:16];

    // Full 32x32 products.
    // Signed and unsigned forms share the same operand copies.
    wire signed [63:0] s_prod = 64'(signed'(op_a_q))
                                * 64'(signed'(op_b_q));
    wire        [63:0] u_prod = 64'(op_a_q) * 64'(op_b_q);
    // Rounding bias enters the full product before extraction.
    // The long forms use the unbiased product.
    wire [63:0] s_rnd = s_prod + (round_q ? `SMU_ROUND_BIAS
                                          : 64'h0);
    wire [31:0] mw    = s_rnd[63:32];
    // Accumulator pair captured at start as one 64-bit word.
    wire [63:0] acc_wide = acc_q;

    // Result selection.
    // Narrow forms leave the upper half of res_d at zero.
    logic [63:0] res_d;
    logic        ovf_ev;
    logic        wide;
    always_comb begin
        res_d  = 64'h0;
        ovf_ev = 1'b0;
        wide   = 1'b0;
        unique case (op_q)
            SMU_OP_HW_MAC:    res_d[31:0] = op_c_q + mw;
            SMU_OP_HW_MSUB:   res_d[31:0] = op_c_q - mw;
            SMU_OP_HW_PROD:   res_d[31:0] = mw;
            SMU_OP_DUAL_SUM: begin
                res_d[31:0] = dual_sum[31:0];
                ovf_ev      = dual_ovf;
            end
            SMU_OP_DUAL_DIFF: res_d[31:0] = dual_diff;
            SMU_OP_HALF_PROD: res_d[31:0] = half_prod;
            SMU_OP_WORD_HALF: res_d[31:0] = wh_top;
            SMU_OP_UWIDE: begin
                res_d = u_prod;
                wide  = 1'b1;
            end
            SMU_OP_UWIDE_MAC: begin
                res_d = u_prod + acc_wide;
                wide  = 1'b1;
            end
            SMU_OP_SWIDE: begin
                res_d = s_prod;
                wide  = 1'b1;
            end
            SMU_OP_SWIDE_MAC: begin
                res_d = s_prod + acc_wide;
                wide  = 1'b1;
            end
            // Codes 11 to 15 are unused and give a zero result.
            default: begin
                res_d = 64'h0;
            end
        endcase
    end

    // --------------------------------------------------------------
    // Sequencer: capture, compute, write back
    // --------------------------------------------------------------
    // Operands are copied at start so a result register can alias a
    // source register without corrupting the computation.
    // A start is honoured only when idle; one that comes while busy
    // is dropped, so the operation in flight is never disturbed.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= SMU_IDLE;
            op_a_q  <= 32'h0;
            op_b_q  <= 32'h0;
            op_c_q  <= 32'h0;
            acc_q   <= 64'h0;
            op_q    <= SMU_OP_HW_MAC;
            round_q <= 1'b0;
            swap_q  <= 1'b0;
            xtop_q  <= 1'b0;
            ytop_q  <= 1'b0;
        end else begin
            unique case (state_q)
                SMU_IDLE: if (start) begin
                    op_a_q  <= first_factor_q;
                    op_b_q  <= second_factor_q;
                    op_c_q  <= addend_value_q;
                    acc_q   <= {upper_result_word_q,
                                lower_result_word_q};
                    op_q    <= smu_op_t'(ctrl_q[3:0]);
                    round_q <= ctrl_q[`SMU_CTRL_ROUND];
                    swap_q  <= ctrl_q[`SMU_CTRL_SWAP];
                    xtop_q  <= ctrl_q[`SMU_CTRL_XTOP];
                    ytop_q  <= ctrl_q[`SMU_CTRL_YTOP];
                    state_q <= SMU_CALC;
                end
                // One cycle lets the wide adders settle.
                SMU_CALC:  state_q <= SMU_WRITE;
                // Write back, then free the unit for the next start.
                SMU_WRITE: state_q <= SMU_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Software registers and results
    // --------------------------------------------------------------
    // Results land in the write-back state, two cycles after start.
    wire writing = (state_q == SMU_WRITE);
    wire done_ev = writing;
    wire ovf_hit = writing & ovf_ev;

    // Data words take byte-lane writes; a wide result in the
    // write-back cycle wins over a bus write to the same word.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_q              <= 8'h00;
            first_factor_q      <= 32'h0;
            second_factor_q     <= 32'h0;
            addend_value_q      <= 32'h0;
            lower_result_word_q <= 32'h0;
            upper_result_word_q <= 32'h0;
            result_q            <= 32'h0;
        end else begin
            // The control word has only its low byte.
            if (hit_ctrl & avs_byteenable[0]) begin
                ctrl_q <= avs_writedata[7:0];
            end
            if (hit_first) begin
                first_factor_q <= be_merge(first_factor_q,
                                           avs_writedata, avs_byteenable);
            end
            if (hit_second) begin
                second_factor_q <= be_merge(second_factor_q,
                                            avs_writedata, avs_byteenable);
            end
            if (hit_addend) begin
                addend_value_q <= be_merge(addend_value_q,
                                           avs_writedata, avs_byteenable);
            end

            // Wide results fill both words of the pair.
            if (writing & wide) begin
                lower_result_word_q <= res_d[31:0];
                upper_result_word_q <= res_d[63:32];
            end else begin
                if (hit_lower) begin
                    lower_result_word_q <= be_merge(lower_result_word_q,
                                        avs_writedata, avs_byteenable);
                end
                if (hit_upper) begin
                    upper_result_word_q <= be_merge(upper_result_word_q,
                                        avs_writedata, avs_byteenable);
                end
            end

            // Narrow results go to their own read-only word.
            if (writing & !wide) begin
                result_q <= res_d[31:0];
            end
        end
    end

    // Sticky flags: hardware set wins over a software clear.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sticky_ovf_q <= 1'b0;
            status_q     <= 2'b00;
            mask_q       <= 2'b00;
        end else begin
            // Only the dual sum raises overflow; other ops keep it.
            if (ovf_hit) begin
                sticky_ovf_q <= 1'b1;
            end else if (hit_flags & avs_byteenable[0]) begin
                sticky_ovf_q <= avs_writedata[0];
            end

            // Write one to clear; an event in the same cycle wins.
            status_q[`SMU_ST_DONE] <= done_ev
                | (status_q[`SMU_ST_DONE] & !(hit_status
                & avs_byteenable[0] & avs_writedata[`SMU_ST_DONE]));
            status_q[`SMU_ST_OVF] <= ovf_hit
                | (status_q[`SMU_ST_OVF] & !(hit_status
                & avs_byteenable[0] & avs_writedata[`SMU_ST_OVF]));

            // Mask bits follow the status layout.
            if (hit_mask & avs_byteenable[0]) begin
                mask_q <= avs_writedata[1:0];
            end
        end
    end

    // --------------------------------------------------------------
    // Read mux and bus handshake
    // --------------------------------------------------------------
    // Bit 3 of the control word reads as busy so software can poll
    // it; unmapped words read as zero.
    logic [31:0] rd_mux;
    always_comb begin
        unique case (word_idx)
            `SMU_ADDR_CTRL:   rd_mux = {28'h0, state_q != SMU_IDLE,
                                        3'h0} | {24'h0, ctrl_q & 8'hF7};
            `SMU_ADDR_FIRST:  rd_mux = first_factor_q;
            `SMU_ADDR_SECOND: rd_mux = second_factor_q;
            `SMU_ADDR_ADDEND: rd_mux = addend_value_q;
            `SMU_ADDR_LOWER:  rd_mux = lower_result_word_q;
            `SMU_ADDR_UPPER:  rd_mux = upper_result_word_q;
            `SMU_ADDR_RESULT: rd_mux = result_q;
            `SMU_ADDR_STATUS: rd_mux = {30'h0, status_q};
            `SMU_ADDR_MASK:   rd_mux = {30'h0, mask_q};
            `SMU_ADDR_FLAGS:  rd_mux = {31'h0, sticky_ovf_q};
            default:          rd_mux = 32'h0;
        endcase
    end

    // One wait cycle per access; waitrequest drops for one cycle.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wait_q         <= 1'b1;
            avs_readdata_q <= 32'h0;
            irq_q          <= 1'b0;
        end else begin
            wait_q <= !acc_req;

            // Read data are captured as the request is first seen and
            // stand until the next read, so the master finds them at
            // the edge where waitrequest is low.
            if (avs_read & wait_q) begin
                avs_readdata_q <= rd_mux;
            end

            // Registered so the pin comes from a flip-flop; it lags
            // the status and mask by one cycle.
            irq_q <= |(status_q & mask_q);
        end
    end

    // Outputs come straight from flip-flops.
    assign avs_readdata    = avs_readdata_q;
    assign avs_waitrequest = wait_q;
    assign irq             = irq_q;

endmodule

// >>> verif/smu_mul_properties.sv
// Bus, interrupt and sticky flag properties of the multiply unit.
`timescale 1ns/1ps

module smu_mul_checker (
    input wire logic        clk_sys,         // Core clock.
    input wire logic        reset,           // Async reset, high.
    input wire logic [5:0]  avs_address,     // Byte address.
    input wire logic        avs_read,        // Read strobe.
    input wire logic        avs_write,       // Write strobe.
    input wire logic [31:0] avs_writedata,   // Write data.
    input wire logic [3:0]  avs_byteenable,  // Byte lanes.
    input wire logic [31:0] avs_readdata,    // Read data.
    input wire logic        avs_waitrequest, // Slave stall.
    input wire logic        irq              // Level interrupt.
);
    // ----------------------------
    // Access decode and shadows
    // ----------------------------
    // An access completes where a strobe meets a low waitrequest.
    wire       acc     = (avs_read || avs_write) && !avs_waitrequest;
    wire [3:0] idx     = avs_address[5:2];
    wire       clr_acc = acc && avs_write && (idx == 4'h7 || idx == 4'h8);
    logic      mask_zero_q;
    logic      flag_seen_q;

    // A partial-lane mask write counts as nonzero, so the quiet check
    // stays silent whenever the shadow cannot be sure.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mask_zero_q <= 1'b1;
            flag_seen_q <= 1'b0;
        end else begin
            if (acc && avs_write && idx == 4'h8)
                mask_zero_q <= avs_byteenable == 4'hF && !(|avs_writedata);
            if (acc && idx == 4'h9)
                flag_seen_q <= avs_read && avs_readdata[0];
        end
    end

    // ----------------------------
    // Properties
    // ----------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence req_pending;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    answer_next_a: assert property (
        req_pending |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("Request not answered in one cycle.");
    idle_wait_a: assert property (
        !(avs_read || avs_write) |=> avs_waitrequest)
        else $error("Waitrequest low without a request.");
    unmapped_zero_a: assert property (
        acc && avs_read && idx > 4'h9 |-> avs_readdata == 32'h0)
        else $error("Unmapped read returned nonzero.");
    read_hold_a: assert property (
        $changed(avs_readdata) |-> $past(avs_read))
        else $error("Read data changed without a read.");
    mask_quiet_a: assert property (mask_zero_q [*3] |-> !irq)
        else $error("Interrupt high with all sources masked.");
    irq_rise_a: assert property ($rose(irq) |->
        !mask_zero_q || !$past(mask_zero_q) || !$past(mask_zero_q, 2))
        else $error("Interrupt rose with mask clear.");
    irq_fall_a: assert property ($fell(irq) |->
        $past(clr_acc) || $past(clr_acc, 2) || $past(clr_acc, 3))
        else $error("Interrupt fell without a clear or mask write.");
    flag_sticky_a: assert property (
        acc && avs_read && idx == 4'h9 && flag_seen_q |-> avs_readdata[0])
        else $error("Sticky overflow flag lost without a write.");
endmodule

bind smu_mul_unit smu_mul_checker u_smu_chk (
    .clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq
);

// >>> verif/smu_host_model.sv
// Bus master standing in for the core's decoder and register file.
`timescale 1ns/1ps

module smu_host_model (
    input  wire logic        clk_sys,         // Core clock.
    input  wire logic [31:0] avs_readdata,    // Read data.
    input  wire logic        avs_waitrequest, // Slave stall.
    output logic      [5:0]  avs_address,     // Byte address.
    output logic             avs_read,        // Read strobe.
    output logic             avs_write,       // Write strobe.
    output logic      [31:0] avs_writedata,   // Write data.
    output logic      [3:0]  avs_byteenable   // Byte lanes.
);
    // Idle at time zero; every access uses all four lanes.
    initial begin
        avs_address    = 6'h3F;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hF;
    end

    // Operands sit at fixed places, so no stack or program pointer can be
    // named and the two result halves never share a place.
    task automatic bus_write(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        // Released lines show the inverse, never a stale copy.
        avs_write     <= 1'b0;
        avs_address   <= ~a;
        avs_writedata <= ~d;
    endtask

    // Read data is taken at the edge that samples waitrequest low.
    task automatic bus_read(input logic [5:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read    <= 1'b0;
        avs_address <= ~a;
    endtask
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the multiply unit over its register bus.
`timescale 1ns/1ps

module testbench;
    localparam logic [31:0] OP_P = 32'h8001_7FFD;
    localparam logic [31:0] OP_Q = 32'hFFFE_8003;
    logic        clk_sys;
    logic        reset;
    logic [5:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    logic        exp_ovf;
    int          n_fail = 0;
    int          check_count = 0;
    int          cycles = 0;

    smu_mul_unit uut (.clk_sys, .reset, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .irq);
    smu_host_model host (.clk_sys, .avs_readdata, .avs_waitrequest,
        .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable);

    // ----------------------------
    // Checking helpers
    // ----------------------------
    // Bit 64 of the model's answer is the expected overflow event.
    function automatic logic [64:0] model(input logic [7:0] cfg,
        input logic [31:0] a, b, c, lo, hi);
        logic signed [63:0] sa, sb, p, q, r;
        logic signed [15:0] x, y;
        logic [31:0] bs;
        sa = $signed(a);
        sb = $signed(b);
        bs = cfg[5] ? {b[15:0], b[31:16]} : b;
        x = cfg[6] ? a[31:16] : a[15:0];
        y = cfg[7] ? b[31:16] : b[15:0];
        p = sa * sb + (cfg[4] ? 64'sh8000_0000 : 64'sh0);
        q = $signed(a[15:0]) * $signed(bs[15:0]);
        r = $signed(a[31:16]) * $signed(bs[31:16]);
        case (cfg[3:0])
            4'h0: return {33'h0, p[63:32] + c};
            4'h1: return {33'h0, c - p[63:32]};
            4'h2: return {33'h0, p[63:32]};
            4'h3: begin
                q = q + r;
                return {|q[63:31] && !(&q[63:31]), 32'h0, q[31:0]};
            end
            4'h4: return {33'h0, q[31:0] - r[31:0]};
            4'h5: return {33'h0, 32'(x * y)};
            4'h6: begin
                q = sa * y;
                return {33'h0, q[47:16]};
            end
            4'h7: return {1'b0, {32'h0, a} * {32'h0, b}};
            4'h8: return {1'b0, {32'h0, a} * {32'h0, b} + {hi, lo}};
            4'h9: return {1'b0, sa * sb};
            default: return {1'b0, sa * sb + $signed({hi, lo})};
        endcase
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // The unit takes its configuration from the control value held before
    // the start write, so configuration goes first and wide results are
    // loaded after it, in case the first write launched a stale operation.
    task automatic run_op(input logic [7:0] cfg, input logic [31:0] a, b,
        input logic [31:0] c = 0, lo = 0, hi = 0);
        logic [64:0] e;
        logic [31:0] d;
        e = model(cfg, a, b, c, lo, hi);
        exp_ovf = exp_ovf | e[64];
        host.bus_write(6'h00, {24'h0, cfg});
        host.bus_write(6'h04, a);
        host.bus_write(6'h08, b);
        host.bus_write(6'h0C, c);
        host.bus_write(6'h10, lo);
        host.bus_write(6'h14, hi);
        host.bus_write(6'h1C, 32'h1);
        host.bus_write(6'h00, {24'h0, cfg | 8'h08});
        d = 32'h0;
        for (int n = 0; n < 20 && d[0] !== 1'b1; n++) host.bus_read(6'h1C, d);
        check(d & 32'h1, 32'h1);
        if (cfg[3:0] > 4'h6) begin
            host.bus_read(6'h10, d);
            check(d, e[31:0]);
            host.bus_read(6'h14, d);
            check(d, e[63:32]);
        end else begin
            host.bus_read(6'h18, d);
            check(d, e[31:0]);
        end
        host.bus_read(6'h24, d);
        check(d & 32'h1, {31'h0, exp_ovf});
    endtask

    // The interrupt lags its cause by one cycle, so look two edges later.
    task automatic irq_step(input logic [5:0] a, input logic [31:0] v,
        input logic e);
        host.bus_write(a, v);
        repeat (2) @(posedge clk_sys);
        check({31'h0, irq}, {31'h0, e});
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------------------------
    // Clock, timeout and sequence
    // ----------------------------
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // About 1000 cycles are needed; the ceiling leaves wide margin.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        logic [31:0] d;
        reset   = 1'b1;
        exp_ovf = 1'b0;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        host.bus_write(6'h18, 32'hFFFF_FFFF);
        host.bus_write(6'h28, 32'hFFFF_FFFF);
        for (int i = 0; i < 11; i++) begin
            host.bus_read(6'(i * 4), d);
            check(d, 32'h0);
        end
        for (int k = 0; k < 6; k++)
            run_op(8'(k % 3 + k / 3 * 16), OP_P, OP_Q, OP_Q);
        run_op(8'h12, 32'h0001_0003, 32'h8000_0001);
        for (int k = 0; k < 4; k++)
            run_op(8'(3 + k % 2 + k / 2 * 32), OP_P, OP_Q);
        for (int k = 0; k < 4; k++)
            run_op(8'(5 + k * 64), OP_P, OP_Q);
        for (int k = 0; k < 2; k++)
            run_op(8'(6 + k * 128), OP_P, OP_Q);
        for (int k = 0; k < 4; k++)
            run_op(8'(7 + k), OP_P, OP_Q, 0, OP_Q, OP_P);
        run_op(8'h03, 32'h8000_8000, 32'h8000_8000);
        run_op(8'h02, OP_P, OP_Q);
        run_op(8'h09, OP_Q, OP_Q);
        host.bus_write(6'h24, 32'h0);
        exp_ovf = 1'b0;
        host.bus_read(6'h24, d);
        check(d & 32'h1, 32'h0);
        check({31'h0, irq}, 32'h0);
        irq_step(6'h20, 32'h1, 1'b1);
        irq_step(6'h20, 32'h0, 1'b0);
        irq_step(6'h20, 32'h1, 1'b1);
        irq_step(6'h1C, 32'h1, 1'b0);
        give_verdict();
    end
endmodule
